// File: cfdts_core.sv
// Function
// - Counter runs when enabled, else cleared
// - Counter advances every prescale plus one clocks
// - FD frames stamp after FDF when selected
// - Stamp at frame valid when control set
// - Otherwise classical frames stamp at SOF
// - Receive code names highest FIFO, none 40
// - Transmit code names highest FIFO, none 40
// - Highest pending code number wins
// - Filter hit field holds matching filter
// - Global codes for attempt, event, bad message
// - Global codes for mode, timer, buffer fault
// - Global codes for address, overflow, wake, error
// - Global none is 40, FIFO codes below
// - Read/write enable bits gate each source
// - Hardware sets sticky flags, write zero clears
// - RAM collision raises system error flag
// - Summary flags are read only
// - Buffer fault reported for either cause
// - Timer flag set on counter wrap
// - Receive pending is OR of enabled flags
// - Mode flag set when actual meets requested
`timescale 1ns/1ns
`default_nettype none
`include "cfdts_defines.svh"
module cfdts_core
	import cfdts_pkg::*;
#(
	parameter int AW = 8, // APB address width
	parameter int NF = 32, // Number of FIFOs
	parameter int NFL = 3 // Receive flags per FIFO
) (
	input wire logic i_clock, // System clock, 10 MHz
	input wire logic i_rst_b, // Async reset, active low
	input wire logic i_psel, // APB select
	input wire logic i_penable, // APB enable
	input wire logic i_pwrite, // APB direction
	input wire logic [AW-1:0] i_paddr, // APB byte address
	input wire logic [31:0] i_pwdata, // APB write data
	output logic [31:0] o_prdata, // APB read data
	output logic o_pready, // APB ready
	output logic o_pslverr, // APB error, unmapped
	input wire logic i_sof_sample, // Sample point of SOF
	input wire logic i_res_sample, // Sample point of bit after FDF
	input wire logic i_frame_is_fd, // Current frame is FD
	input wire logic i_rx_eof_valid, // Received frame became valid
	input wire logic i_tx_eof_valid, // Sent frame became valid
	output logic o_stamp_valid, // Stamp taken, one cycle
	output logic [31:0] o_stamp_value, // Captured stamp
	input wire logic i_filter_hit_valid, // Filter matched
	input wire logic [4:0] i_filter_hit_index, // Matching filter
	input wire logic i_bad_msg_evt, // Invalid message pulse
	input wire logic i_wake_evt, // Bus wake-up pulse
	input wire logic i_bus_err_evt, // Bus error pulse
	input wire logic i_ram_collision, // Message RAM collision
	input wire logic i_mab_fault, // Assembly buffer over/underflow
	input wire logic i_fifo_addr_err, // Illegal FIFO address
	input wire logic [2:0] i_actual_op_mode, // Actual mode
	input wire logic [2:0] i_requested_op_mode, // Requested mode
	input wire logic i_rx_ovf_any, // Any receive overflow
	input wire logic i_tx_attempt_any, // Any attempt flag
	input wire logic i_serial_crc_any, // Serial CRC error
	input wire logic i_ecc_any, // ECC error
	input wire logic i_tx_event_any, // Any transmit event flag
	input wire logic [NF*NFL-1:0] i_rx_fifo_flags, // Per FIFO flags
	input wire logic [NF*NFL-1:0] i_rx_fifo_flag_en, // Their enables
	input wire logic [NF-1:0] i_tx_fifo_pending, // Transmit pending
	output logic o_irq // Module interrupt request
);
	// -------------------------------------------------------------
	// APB decode
	// -------------------------------------------------------------
	logic apb_wr; // Write takes effect this edge
	logic hit; // Address is mapped
	logic [31:0] rd_word; // Selected read word
	assign apb_wr = i_psel & i_penable & o_pready & i_pwrite;

	// Zero wait: ready rises with the setup edge
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0000_0000;
		end else begin
			o_pready <= i_psel & ~i_penable;
			o_pslverr <= i_psel & ~i_penable & ~hit;
			o_prdata <= (i_psel & ~i_penable & ~i_pwrite) ? rd_word : 32'h0000_0000;
		end
	end

	// -------------------------------------------------------------
	// Time stamp control register
	// -------------------------------------------------------------
	logic fd_stamp_point_sel; // Stamp after FDF for FD frames
	logic stamp_at_frame_valid; // Stamp when frame valid
	logic timebase_enable; // Counter runs
	logic [9:0] timebase_prescale; // Divide by N+1
	logic tscon_wr; // Write to control

	assign tscon_wr = apb_wr && (i_paddr == AW'(`CFDTS_OFS_TSCON));

	// Only bits 18..16 and 9..0 are stored
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			fd_stamp_point_sel <= 1'b0;
			stamp_at_frame_valid <= 1'b0;
			timebase_enable <= 1'b0;
			timebase_prescale <= 10'h000;
		end else if (tscon_wr) begin
			fd_stamp_point_sel <= i_pwdata[`CFDTS_TS_FDSEL];
			stamp_at_frame_valid <= i_pwdata[`CFDTS_TS_EOF];
			timebase_enable <= i_pwdata[`CFDTS_TS_TBEN];
			timebase_prescale <= i_pwdata[`CFDTS_TS_PRE_MSB:0];
		end
	end

	// -------------------------------------------------------------
	// Time base counter
	// -------------------------------------------------------------
	logic [31:0] timebase_counter; // Live count
	logic timer_ovf_src; // Wrap pulse
	logic tbc_wr; // Write to counter

	assign tbc_wr = apb_wr && (i_paddr == AW'(`CFDTS_OFS_TBC));

	cfdts_timebase #(
		.CW(32),
		.PW(10)
	) u_timebase (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_enable(timebase_enable),
		.i_prescale(timebase_prescale),
		.i_load(tbc_wr),
		.i_load_value(i_pwdata),
		.o_count(timebase_counter),
		.o_wrap(timer_ovf_src)
	);

	// -------------------------------------------------------------
	// Time stamp capture
	// -------------------------------------------------------------
	cfdts_frame_t frame_state; // Tracking SOF hold
	logic [31:0] sof_hold; // Count at SOF sample point

	// FD is known only after FDF, so hold the SOF count
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			frame_state <= FRM_IDLE;
			sof_hold <= 32'h0000_0000;
			o_stamp_valid <= 1'b0;
			o_stamp_value <= 32'h0000_0000;
		end else begin
			o_stamp_valid <= 1'b0;
			if (stamp_at_frame_valid) begin
				frame_state <= FRM_IDLE;
				if (i_rx_eof_valid | i_tx_eof_valid) begin
					// Valid point differs for receive and transmit
					o_stamp_valid <= 1'b1;
					o_stamp_value <= timebase_counter;
				end
			end else begin
				unique case (frame_state)
					FRM_IDLE: begin
						if (i_sof_sample) begin
							sof_hold <= timebase_counter;
							frame_state <= FRM_SOF_HELD;
						end
					end
					FRM_SOF_HELD: begin
						if (i_sof_sample) begin
							// A new SOF restarts the frame
							sof_hold <= timebase_counter;
						end else if (i_res_sample) begin
							o_stamp_valid <= 1'b1;
							frame_state <= FRM_IDLE;
							if (i_frame_is_fd && fd_stamp_point_sel) begin
								o_stamp_value <= timebase_counter;
							end else begin
								o_stamp_value <= sof_hold;
							end
						end
					end
				endcase
			end
		end
	end

	// -------------------------------------------------------------
	// Per FIFO pending bits
	// -------------------------------------------------------------
	logic [NF-1:0] rx_fifo_pending; // Receive pending per FIFO
	logic [NF-1:0] tx_fifo_pending; // Transmit pending per FIFO

	// FIFO 0 is transmit only, so its receive bit stays zero
	for (genvar g = 0; g < NF; g++) begin : g_rxpend
		if (g == 0) begin : g_zero
			assign rx_fifo_pending[g] = 1'b0;
		end else begin : g_or
			assign rx_fifo_pending[g] =
				|(i_rx_fifo_flags[g*NFL +: NFL] & i_rx_fifo_flag_en[g*NFL +: NFL]);
		end
	end
	assign tx_fifo_pending = i_tx_fifo_pending;

	// -------------------------------------------------------------
	// Read-only summary flags
	// -------------------------------------------------------------
	logic rx_ovf_flag; // Receive overflow summary
	logic tx_attempt_flag; // Attempt summary
	logic serial_crc_flag; // Serial CRC summary
	logic ecc_flag; // ECC summary
	logic tx_event_flag; // Event FIFO summary
	logic rx_obj_flag; // Any receive FIFO pending
	logic tx_obj_flag; // Any transmit FIFO pending

	// Registered; writes never reach them
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rx_ovf_flag <= 1'b0;
			tx_attempt_flag <= 1'b0;
			serial_crc_flag <= 1'b0;
			ecc_flag <= 1'b0;
			tx_event_flag <= 1'b0;
			rx_obj_flag <= 1'b0;
			tx_obj_flag <= 1'b0;
		end else begin
			rx_ovf_flag <= i_rx_ovf_any;
			tx_attempt_flag <= i_tx_attempt_any;
			serial_crc_flag <= i_serial_crc_any;
			ecc_flag <= i_ecc_any;
			tx_event_flag <= i_tx_event_any;
			rx_obj_flag <= |rx_fifo_pending;
			tx_obj_flag <= |tx_fifo_pending;
		end
	end

	// -------------------------------------------------------------
	// Interrupt enables and sticky flags
	// -------------------------------------------------------------
	logic [7:0] en_hi; // bad, wake, buserr, syserr, rxovf, txat, crc, ecc
	logic [4:0] en_lo; // tef, mode, timer, rx obj, tx obj
	logic int_wr; // Write to interrupt register
	logic [5:0] sticky; // bad, wake, buserr, syserr, mode, timer
	logic [5:0] sticky_set; // Hardware set events
	logic [5:0] sticky_clr; // Software clear mask
	logic mab_cause; // System error from buffer fault
	logic addr_cause; // System error from address or collision
	logic [2:0] prev_mode; // Actual mode last cycle
	logic mode_set; // Mode reached request
	logic sys_err_set; // Any system error cause

	assign int_wr = apb_wr && (i_paddr == AW'(`CFDTS_OFS_INT));
	assign mode_set = (i_actual_op_mode != prev_mode) &&
		(i_actual_op_mode == i_requested_op_mode);
	assign sys_err_set = i_ram_collision | i_mab_fault | i_fifo_addr_err;
	assign sticky_set = {i_bad_msg_evt, i_wake_evt, i_bus_err_evt, sys_err_set,
		mode_set, timer_ovf_src};
	// Write one keeps a flag, zero clears it
	assign sticky_clr = int_wr ? ~{i_pwdata[`CFDTS_INT_BAD], i_pwdata[`CFDTS_INT_WAKE],
		i_pwdata[`CFDTS_INT_BUSERR], i_pwdata[`CFDTS_INT_SYSERR],
		i_pwdata[`CFDTS_INT_MODE], i_pwdata[`CFDTS_INT_TMR]} : 6'h00;

	// Plain read/write enables
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			en_hi <= 8'h00;
			en_lo <= 5'h00;
		end else if (int_wr) begin
			en_hi <= i_pwdata[`CFDTS_INT_ENHI_LSB +: 8];
			en_lo <= i_pwdata[`CFDTS_INT_ENLO_LSB +: 5];
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sticky <= 6'h00;
			mab_cause <= 1'b0;
			addr_cause <= 1'b0;
			prev_mode <= 3'h0;
		end else begin
			prev_mode <= i_actual_op_mode;
			sticky <= sticky_set | (sticky & ~sticky_clr);
			mab_cause <= i_mab_fault | (mab_cause & ~sticky_clr[2]);
			addr_cause <= i_fifo_addr_err | i_ram_collision | (addr_cause & ~sticky_clr[2]);
		end
	end

	// -------------------------------------------------------------
	// Vector codes
	// -------------------------------------------------------------
	logic [12:0] flags_all; // All flags, enable order
	logic [12:0] active; // Flags with enables
	cfdts_code_t next_rx_code; // Receive code
	cfdts_code_t next_tx_code; // Transmit code
	cfdts_code_t next_g_code; // Global code
	cfdts_code_t rx_vector_code; // Registered receive code
	cfdts_code_t tx_vector_code; // Registered transmit code
	cfdts_code_t global_vector_code; // Registered global code
	logic [4:0] filter_match_index; // Last matching filter

	assign flags_all = {sticky[5:2], rx_ovf_flag, tx_attempt_flag, serial_crc_flag,
		ecc_flag, tx_event_flag, sticky[1:0], rx_obj_flag, tx_obj_flag};
	assign active = flags_all & {en_hi, en_lo};

	// Ascending scan: highest number wins
	always_comb begin
		next_rx_code = `CFDTS_CODE_NONE;
		next_tx_code = `CFDTS_CODE_NONE;
		next_g_code = `CFDTS_CODE_NONE;
		for (int i = 0; i < NF; i++) begin
			if (rx_fifo_pending[i]) begin
				next_rx_code = 7'(i);
			end
			if (tx_fifo_pending[i]) begin
				next_tx_code = 7'(i);
			end
			if ((rx_fifo_pending[i] & en_lo[1]) | (tx_fifo_pending[i] & en_lo[0])) begin
				next_g_code = 7'(i);
			end
		end
		if (active[10]) next_g_code = `CFDTS_CODE_CERR;
		if (active[11]) next_g_code = `CFDTS_CODE_WAKE;
		if (active[8]) next_g_code = `CFDTS_CODE_RXOV;
		if (active[9] & addr_cause) next_g_code = `CFDTS_CODE_ADDR;
		if (active[9] & mab_cause) next_g_code = `CFDTS_CODE_MAB;
		if (active[2]) next_g_code = `CFDTS_CODE_TMR;
		if (active[3]) next_g_code = `CFDTS_CODE_MODE;
		if (active[12]) next_g_code = `CFDTS_CODE_IVM;
		if (active[4]) next_g_code = `CFDTS_CODE_TEF;
		if (active[7]) next_g_code = `CFDTS_CODE_TXAT;
	end

	// Codes lag flags one cycle, glitch free
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rx_vector_code <= `CFDTS_CODE_NONE;
			tx_vector_code <= `CFDTS_CODE_NONE;
			global_vector_code <= `CFDTS_CODE_NONE;
		end else begin
			rx_vector_code <= next_rx_code;
			tx_vector_code <= next_tx_code;
			global_vector_code <= next_g_code;
		end
	end

	// Filter index holds until the next match
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			filter_match_index <= 5'h00;
		end else if (i_filter_hit_valid) begin
			filter_match_index <= i_filter_hit_index;
		end
	end

	// -------------------------------------------------------------
	// Interrupt request
	// -------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |active;
		end
	end

	// -------------------------------------------------------------
	// Read mux
	// -------------------------------------------------------------
	always_comb begin
		hit = 1'b1;
		rd_word = 32'h0000_0000;
		unique case (i_paddr)
			AW'(`CFDTS_OFS_TSCON): rd_word = {13'h0000, fd_stamp_point_sel,
				stamp_at_frame_valid, timebase_enable, 6'h00, timebase_prescale};
			AW'(`CFDTS_OFS_VEC): rd_word = {1'b0, rx_vector_code, 1'b0, tx_vector_code,
				3'h0, filter_match_index, 1'b0, global_vector_code};
			AW'(`CFDTS_OFS_INT): rd_word = {en_hi, 3'h0, en_lo, flags_all[12:5],
				3'h0, flags_all[4:0]};
			AW'(`CFDTS_OFS_TBC): rd_word = timebase_counter;
			AW'(`CFDTS_OFS_RXPEND): rd_word = 32'(rx_fifo_pending);
			AW'(`CFDTS_OFS_TXPEND): rd_word = 32'(tx_fifo_pending);
			default: hit = 1'b0;
		endcase
	end
endmodule // cfdts_core
`default_nettype wire

// File: cfdts_defines.svh
`ifndef CFDTS_DEFINES_SVH
`define CFDTS_DEFINES_SVH
// -------------------------------------------------------------
// Register byte offsets
// -------------------------------------------------------------
`define CFDTS_OFS_TSCON 8'h00
`define CFDTS_OFS_VEC 8'h04
`define CFDTS_OFS_INT 8'h08
`define CFDTS_OFS_TBC 8'h0c
`define CFDTS_OFS_RXPEND 8'h10
`define CFDTS_OFS_TXPEND 8'h14
// -------------------------------------------------------------
// Time stamp control fields
// -------------------------------------------------------------
`define CFDTS_TS_FDSEL 18
`define CFDTS_TS_EOF 17
`define CFDTS_TS_TBEN 16
`define CFDTS_TS_PRE_MSB 9
`define CFDTS_TS_RESET 32'h0000_0000
// -------------------------------------------------------------
// Interrupt register fields
// -------------------------------------------------------------
`define CFDTS_INT_ENHI_LSB 24
`define CFDTS_INT_ENLO_LSB 16
`define CFDTS_INT_BAD 15
`define CFDTS_INT_WAKE 14
`define CFDTS_INT_BUSERR 13
`define CFDTS_INT_SYSERR 12
`define CFDTS_INT_MODE 3
`define CFDTS_INT_TMR 2
// -------------------------------------------------------------
// Vector codes
// -------------------------------------------------------------
`define CFDTS_CODE_NONE 7'h40
`define CFDTS_CODE_CERR 7'h41
`define CFDTS_CODE_WAKE 7'h42
`define CFDTS_CODE_RXOV 7'h43
`define CFDTS_CODE_ADDR 7'h44
`define CFDTS_CODE_MAB 7'h45
`define CFDTS_CODE_TMR 7'h46
`define CFDTS_CODE_MODE 7'h47
`define CFDTS_CODE_IVM 7'h48
`define CFDTS_CODE_TEF 7'h49
`define CFDTS_CODE_TXAT 7'h4a
`endif

// File: cfdts_pkg.sv
package cfdts_pkg;
	// Vector code field type
	typedef logic [6:0] cfdts_code_t;
	// Frame tracking for start-of-frame stamps
	typedef enum logic [0:0] {FRM_IDLE, FRM_SOF_HELD} cfdts_frame_t;
endpackage

// File: cfdts_timebase.sv
`timescale 1ns/1ns
`default_nettype none
module cfdts_timebase #(
	parameter int CW = 32, // Counter width
	parameter int PW = 10 // Prescaler width
) (
	input wire logic i_clock, // System clock
	input wire logic i_rst_b, // Async reset, active low
	input wire logic i_enable, // Run when high
	input wire logic [PW-1:0] i_prescale, // Divide by N+1
	input wire logic i_load, // Software write strobe
	input wire logic [CW-1:0] i_load_value, // Value written
	output logic [CW-1:0] o_count, // Counter value
	output logic o_wrap // One-cycle wrap pulse
);
	// -------------------------------------------------------------
	// Prescaler and counter
	// -------------------------------------------------------------
	logic [PW-1:0] pre_cnt; // Clocks since last advance

	// A load restarts the prescaler
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pre_cnt <= '0;
			o_count <= '0;
			o_wrap <= 1'b0;
		end else begin
			o_wrap <= 1'b0;
			if (!i_enable) begin
				// Stopped and cleared to save power
				pre_cnt <= '0;
				o_count <= '0;
			end else if (i_load) begin
				pre_cnt <= '0;
				o_count <= i_load_value;
			end else if (pre_cnt == i_prescale) begin
				// Advance once per N+1 clocks
				pre_cnt <= '0;
				o_count <= o_count + 1'b1;
				o_wrap <= &o_count;
			end else begin
				pre_cnt <= pre_cnt + 1'b1;
			end
		end
	end
endmodule // cfdts_timebase
`default_nettype wire

// File: cfdts_props.sv
`timescale 1ns/1ns
`default_nettype none
module cfdts_props #(
	parameter int AW = 8 // APB address width
) (
	input wire logic i_clock, // System clock
	input wire logic i_rst_b, // Async reset, active low
	input wire logic i_psel, // APB select
	input wire logic i_penable, // APB enable
	input wire logic i_pwrite, // APB direction
	input wire logic [AW-1:0] i_paddr, // APB byte address
	input wire logic [31:0] i_pwdata, // APB write data
	input wire logic [31:0] o_prdata, // APB read data
	input wire logic o_pready, // APB ready
	input wire logic o_pslverr, // APB error
	input wire logic i_res_sample, // Bit after FDF point
	input wire logic i_rx_eof_valid, // Received frame valid
	input wire logic i_tx_eof_valid, // Sent frame valid
	input wire logic o_stamp_valid, // Stamp taken
	input wire logic o_irq // Interrupt request
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	logic rd_ok; // Read answer in this cycle
	logic tb_off; // Counter disabled
	assign rd_ok = i_psel && i_penable && o_pready && !i_pwrite;
	// ------
	// Enable tracking
	// ------
	// Inverse of the enable bit
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tb_off <= 1'b1;
		end else if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == 8'h00) begin
			tb_off <= !i_pwdata[16];
		end
	end
	// ------
	// Properties
	// ------
	a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
		else $error("no ready after setup");
	a_err_unmapped: assert property (o_pslverr |-> o_pready && i_paddr > 8'h14)
		else $error("error on a mapped address");
	a_vec_unused_zero: assert property (rd_ok && i_paddr == 8'h04 |->
		(o_prdata & 32'h8080_e080) == 32'h0) else $error("vector spare bits set");
	a_rx_code_legal: assert property (rd_ok && i_paddr == 8'h04 |->
		o_prdata[30:24] == 7'h40 || (o_prdata[30:29] == 2'b00 && o_prdata[28:24] != 5'h0))
		else $error("receive code illegal");
	a_tx_code_legal: assert property (rd_ok && i_paddr == 8'h04 |->
		o_prdata[22:16] == 7'h40 || o_prdata[22:21] == 2'b00) else $error("transmit code illegal");
	a_global_code_legal: assert property (rd_ok && i_paddr == 8'h04 |->
		o_prdata[6:0] <= 7'h4a && o_prdata[6:5] != 2'b01) else $error("global code reserved");
	a_tscon_unused_zero: assert property (rd_ok && i_paddr == 8'h00 |->
		(o_prdata & 32'hfff8_fc00) == 32'h0) else $error("control spare bits set");
	a_int_unused_zero: assert property (rd_ok && i_paddr == 8'h08 |->
		(o_prdata & 32'h00e0_00e0) == 32'h0) else $error("interrupt spare bits set");
	a_stamp_has_cause: assert property (o_stamp_valid |->
		$past(i_res_sample || i_rx_eof_valid || i_tx_eof_valid)) else $error("stamp without cause");
	a_tbc_off_zero: assert property (rd_ok && i_paddr == 8'h0c && tb_off |->
		o_prdata == 32'h0) else $error("stopped counter not zero");
	c_stamp: cover property (o_stamp_valid);
	c_irq: cover property ($rose(o_irq));
	c_slverr: cover property (o_pslverr);
endmodule // cfdts_props
bind cfdts_core cfdts_props #(.AW(AW)) i_props (.i_clock, .i_rst_b, .i_psel, .i_penable,
	.i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_res_sample,
	.i_rx_eof_valid, .i_tx_eof_valid, .o_stamp_valid, .o_irq);
`default_nettype wire

// File: cfdts_can_model.sv
`timescale 1ns/1ns
`default_nettype none
module cfdts_can_model (
	input wire logic i_clock, // System clock
	input wire logic i_rst_b, // Async reset, active low
	input wire logic i_start, // Begin one frame
	input wire logic i_fd, // Frame uses FD format
	input wire logic i_tx, // Own frame, else received
	output logic o_sof, // SOF sample point
	output logic o_res, // Bit after FDF sample point
	output logic o_fd, // FD indication
	output logic o_rx_ok, // Received frame valid
	output logic o_tx_ok // Sent frame valid
);
	int pos; // Position in frame, 0 when idle
	// ------
	// Frame sequencer
	// ------
	// FD line toggles off its sample point
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pos <= 0;
			o_fd <= 1'b0;
		end else begin
			pos <= (pos == 0) ? (i_start ? 1 : 0) : ((pos == 20) ? 0 : pos + 1);
			o_fd <= (pos == 5) ? i_fd : !o_fd;
		end
	end
	assign o_sof = (pos == 1);
	assign o_res = (pos == 6);
	assign o_rx_ok = (pos == 20) && !i_tx;
	assign o_tx_ok = (pos == 20) && i_tx;
endmodule // cfdts_can_model
`default_nettype wire

// File: cfdts_core_bench.sv
`timescale 1ns/1ns
`default_nettype none
module cfdts_core_bench import cfdts_pkg::*;;
	logic i_clock, i_rst_b; // Clock and reset
	logic i_psel, i_penable, i_pwrite; // APB controls
	logic [7:0] i_paddr; // APB address
	logic [31:0] i_pwdata, o_prdata, o_stamp_value, q; // Data words
	logic o_pready, o_pslverr, o_stamp_valid, o_irq, perr; // Answers
	logic i_sof_sample, i_res_sample, i_frame_is_fd, i_rx_eof_valid, i_tx_eof_valid; // Bus
	logic i_filter_hit_valid, start, fd, tx; // Strobes
	logic [4:0] i_filter_hit_index, fil; // Filter number and its model
	logic [11:0] evs; // Event sources
	logic [95:0] i_rx_fifo_flags, i_rx_fifo_flag_en; // Per FIFO receive flags
	logic [31:0] i_tx_fifo_pending; // Transmit pending
	int num_errors, n_checks, cyc; // Counters
	int t_ev[3]; // SOF, res, valid cycles
	localparam logic [31:0] EN = 32'hff1f_0000; // Every enable
	localparam cfdts_code_t CODES [12] = '{7'h48, 7'h42, 7'h41, 7'h44, 7'h45, 7'h44, 7'h47,
		7'h43, 7'h4a, 7'h49, 7'h40, 7'h40}; // Code of each source
	localparam int FBIT [12] = '{15, 14, 13, 12, 12, 12, 3, 11, 10, 4, 9, 8}; // Its flag
	cfdts_core i_dut (.i_clock, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
		.o_prdata, .o_pready, .o_pslverr, .i_sof_sample, .i_res_sample, .i_frame_is_fd,
		.i_rx_eof_valid, .i_tx_eof_valid, .o_stamp_valid, .o_stamp_value, .i_filter_hit_valid,
		.i_filter_hit_index, .i_bad_msg_evt(evs[0]), .i_wake_evt(evs[1]), .i_bus_err_evt(evs[2]),
		.i_ram_collision(evs[3]), .i_mab_fault(evs[4]), .i_fifo_addr_err(evs[5]),
		.i_actual_op_mode({2'b00, evs[6]}), .i_requested_op_mode(3'h1), .i_rx_ovf_any(evs[7]),
		.i_tx_attempt_any(evs[8]), .i_tx_event_any(evs[9]), .i_serial_crc_any(evs[10]),
		.i_ecc_any(evs[11]), .i_rx_fifo_flags, .i_rx_fifo_flag_en, .i_tx_fifo_pending, .o_irq);
	cfdts_can_model i_can (.i_clock, .i_rst_b, .i_start(start), .i_fd(fd), .i_tx(tx),
		.o_sof(i_sof_sample), .o_res(i_res_sample), .o_fd(i_frame_is_fd),
		.o_rx_ok(i_rx_eof_valid), .o_tx_ok(i_tx_eof_valid));
	// ------
	// Clock, cycle log, watchdog
	// ------
	initial begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end
	// Cycles at which bus points were seen
	always @(posedge i_clock) begin
		cyc++;
		if (i_sof_sample) t_ev[0] = cyc;
		if (i_res_sample) t_ev[1] = cyc;
		if (i_rx_eof_valid || i_tx_eof_valid) t_ev[2] = cyc;
	end
	initial begin
		repeat (20000) @(posedge i_clock);
		num_errors++;
		report_and_stop();
	end
	// ------
	// Tasks
	// ------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
		end
	endtask
	// Request holds until ready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		{i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, wr, a, d};
		@(posedge i_clock);
		i_penable <= 1'b1;
		while (o_pready !== 1'b1 && n++ < 50) @(negedge i_clock);
		if (n > 50) num_errors++;
		q = o_prdata;
		perr = o_pslverr;
		@(posedge i_clock);
		{i_psel, i_penable} <= 2'b00;
		@(posedge i_clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ------
	// Main sequence
	// ------
	initial begin
		logic [31:0] d;
		logic [95:0] e96;
		logic [15:0] f;
		logic [11:0] m;
		cfdts_code_t cr, cg;
		int a, b, p, e, s0;
		{i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, fil} = '0;
		{i_filter_hit_valid, i_filter_hit_index, evs, start, fd, tx} = '0;
		{i_rx_fifo_flags, i_rx_fifo_flag_en, i_tx_fifo_pending} = '0;
		i_rst_b = 1'b0;
		void'($urandom(87));
		repeat (6) @(posedge i_clock);
		i_rst_b <= 1'b1;
		@(posedge i_clock);
		rd(8'h04, 32'h4040_0040);
		rd(8'h18, 32'h0);
		chk(perr, 1'b1);
		d = $urandom & 32'hfffe_ffff;
		apb(1'b1, 8'h00, d);
		rd(8'h00, d & 32'h0006_03ff);
		d = $urandom;
		apb(1'b1, 8'h08, d & 32'hffff_0000);
		rd(8'h08, d & EN);
		$display("registers done");
		apb(1'b1, 8'h08, EN);
		apb(1'b1, 8'h00, 32'h0001_03ff);
		apb(1'b1, 8'h0c, 32'h1234_5678);
		rd(8'h0c, 32'h1234_5678);
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h00, 32'h0001_0000);
		rd(8'h0c, 32'h1);
		rd(8'h0c, q + 32'h3);
		apb(1'b1, 8'h0c, 32'hffff_fff0);
		repeat (20) @(posedge i_clock);
		rd(8'h08, EN | 32'h4);
		chk(o_irq, 1'b1);
		apb(1'b1, 8'h08, EN | 32'hffff);
		rd(8'h08, EN | 32'h4);
		apb(1'b1, 8'h08, EN);
		rd(8'h08, EN);
		chk(o_irq, 1'b0);
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h0c, 32'h5);
		rd(8'h0c, 32'h0);
		$display("timebase done");
		// Single sources, then random mixes
		for (int k = 0; k < 16; k++) begin
			m = (k < 12) ? 12'(1 << k) : 12'($urandom);
			cg = 7'h40;
			f = '0;
			for (int j = 0; j < 12; j++) begin
				if (m[j] && CODES[j] > cg) cg = CODES[j];
				if (m[j]) f = f | (16'h1 << FBIT[j]);
			end
			evs <= m;
			@(posedge i_clock);
			evs <= m & 12'hf80;
			repeat (3) @(posedge i_clock);
			rd(8'h04, {16'h4040, 3'b000, fil, 1'b0, cg});
			rd(8'h08, EN | 32'(f));
			chk(o_irq, f != 16'h0);
			apb(1'b1, 8'h08, EN);
			rd(8'h08, EN | 32'(f & 16'h0f10));
			evs <= '0;
			repeat (3) @(posedge i_clock);
			rd(8'h08, EN);
		end
		$display("events done");
		for (int k = 0; k < 6; k++) begin
			p = 3 + ($urandom % 93);
			b = $urandom % 32;
			fil = 5'($urandom);
			e96 = {$urandom, $urandom, $urandom};
			i_rx_fifo_flags <= 96'h1 << p;
			i_rx_fifo_flag_en <= e96;
			i_tx_fifo_pending <= 32'h1 << b;
			i_filter_hit_index <= fil;
			i_filter_hit_valid <= 1'b1;
			@(posedge i_clock);
			i_filter_hit_valid <= 1'b0;
			repeat (3) @(posedge i_clock);
			a = e96[p] ? p / 3 : -1;
			cr = e96[p] ? 7'(a) : 7'h40;
			cg = 7'((a > b) ? a : b);
			rd(8'h04, {1'b0, cr, 1'b0, 7'(b), 3'b000, fil, 1'b0, cg});
			rd(8'h10, e96[p] ? 32'h1 << a : 32'h0);
			rd(8'h14, 32'h1 << b);
		end
		$display("fifo codes done");
		// Frame 0, classical at SOF, sets the reference
		for (int k = 0; k < 8; k++) begin
			d = (k == 0) ? 32'h0 : $urandom;
			apb(1'b1, 8'h00, {13'h0, d[3:2], 1'b1, 16'h0});
			fd <= d[1];
			tx <= d[0];
			start <= 1'b1;
			@(posedge i_clock);
			start <= 1'b0;
			for (int n = 0; n < 40 && o_stamp_valid !== 1'b1; n++) @(negedge i_clock);
			chk(o_stamp_valid, 1'b1);
			e = d[2] ? 2 : ((d[3] && d[1]) ? 1 : 0);
			if (k == 0) s0 = o_stamp_value - t_ev[0];
			chk(o_stamp_value - 32'(s0), 32'(t_ev[e]));
			repeat (25) @(posedge i_clock);
		end
		$display("stamps done");
		report_and_stop();
	end
endmodule // cfdts_core_bench
`default_nettype wire
